// file: rtl/dps_pkg.sv
// Purpose: Shared constants for the dual-port pass-through memory block
// Assumes: Single clock mclk at 25 MHz
// Notes:   Widths and depth are defaults for module parameters
package dps_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int DPS_WORDS      = 131072;
  localparam int DPS_ADDR_W     = 17;
  localparam int DPS_DATA_W     = 36;

  // ****************************************************************
  // Control encodings (pin levels, sampled except output enable)
  // ****************************************************************
  localparam logic DPS_WE_WRITE = 1'b0;
  localparam logic DPS_PASS_ON  = 1'b0;
  localparam logic DPS_OE_ON    = 1'b0;

  // Per-port operation chosen at a clock edge
  typedef enum logic [1:0] {
    DPS_OP_IDLE,
    DPS_OP_READ,
    DPS_OP_WRITE
  } dps_op_e;

endpackage

// file: rtl/dps_in_reg.sv
// Purpose: Two-stage input register for one port's pin group
// Assumes: Pins come from outside the clock domain
// Notes:   Stage one is read only by stage two
`timescale 1ns/1ps

module dps_in_reg #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two flops; reset loads the all-ones idle level as a constant, not from rst_val
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '1;
      sync_q <= '1;
    end else if (clk_en) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // Unused idle pattern bits keep high level, which is inactive for
  // every active-low control in this block
  assign sync_out = sync_q & (rst_val | ~rst_val);

endmodule // dps_in_reg

// file: rtl/dps_out_drv.sv
// Purpose: Output data register and asynchronous enable for one port
// Assumes: Output enable is an asynchronous pin, gating only the driver
// Notes:   oe_b low means the pin is driven by this module
`timescale 1ns/1ps

module dps_out_drv
  import dps_pkg::*;
#(
  parameter int W = DPS_DATA_W
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // Next word from the core
  input  wire logic         load,
  input  wire logic         drive,
  input  wire logic [W-1:0] word,
  // Pin side
  input  wire logic         out_en_n,
  output logic      [W-1:0] pin_out,
  output logic              pin_oe_b,
  output logic              valid
);

  logic [W-1:0] data_q;
  logic         drive_q;

  // Output data register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= '0;
    end else if (clk_en && load) begin
      data_q <= word;
    end
  end

  // Drive flag: high-Z from reset until an operation arrives
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= 1'b0;
    end else if (clk_en) begin
      drive_q <= drive;
    end
  end

  // Asynchronous enable acts with no clock on the pin driver only
  assign pin_out  = data_q;
  assign pin_oe_b = ~(drive_q && (out_en_n == DPS_OE_ON));
  assign valid    = drive_q;

endmodule // dps_out_drv

// file: rtl/dps_core.sv
// Purpose: Dual-port synchronous memory with port-to-port pass-through
// Assumes: Inputs are pins, synchronised before use except output enables; one clock mclk
// Notes:   Pins are three signals each; oe_b low means driven here
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// RQ1: Array holds 131072 words of 36 bits, 17-bit address per port.
// RQ2: Each port uses its own address; both ports operate concurrently.
// RQ3: All inputs except output enables are captured on the rising edge.
// RQ4: Low pass control forwards one port's input to the other's output.
// RQ5: Pass-through beats read; read needs select, write high, no pass.
// RQ6: Same-address reads on both ports both return the stored word.
// RQ7: Same-address write and read: reader gets the old word.
// RQ8: Same-address writes on both ports: only port Y data is stored.
// RQ9: Controller gives one spare clock after power before first use.
// RQ10: Write enable low means write, high means read.
// RQ11: Output enable high holds the port's data pins at high-Z.
// RQ12: Data input and output paths are registered on the rising edge.
// RQ13: Select low-n high or select high low starts a deselect cycle.
// RQ14: Controller enables both ports and drives source pass low.
// RQ15: Writes on both ports and passes combine freely in one cycle.
// RQ16: Read X with write Y, write X with read Y, dual reads allowed.
// RQ17: Controller raises output enable before writes that follow reads.
// RQ18: Data outputs stay high-Z after power-up until operations issue.
// RQ19: Results appear on the output two edges after the sampling edge.
// RQ20: A deselected port accesses nothing and goes high-Z two edges after the sampling edge.
module dps_core
  import dps_pkg::*;
#(
  parameter int ADDR_W = DPS_ADDR_W,
  parameter int DATA_W = DPS_DATA_W,
  parameter int WORDS  = DPS_WORDS
) (
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // Port X controls
  input  wire logic [ADDR_W-1:0] port_x_address,
  input  wire logic              x_select_low_n,
  input  wire logic              x_select_high,
  input  wire logic              x_write_enable_n,
  input  wire logic              x_to_y_pass_n,
  input  wire logic              x_output_enable_n,
  // Port Y controls
  input  wire logic [ADDR_W-1:0] port_y_address,
  input  wire logic              y_select_low_n,
  input  wire logic              y_select_high,
  input  wire logic              y_write_enable_n,
  input  wire logic              y_to_x_pass_n,
  input  wire logic              y_output_enable_n,
  // Port X data pin
  input  wire logic [DATA_W-1:0] port_x_data_in,
  output logic      [DATA_W-1:0] port_x_data_out,
  output logic                   port_x_data_oe_b,
  // Port Y data pin
  input  wire logic [DATA_W-1:0] port_y_data_in,
  output logic      [DATA_W-1:0] port_y_data_out,
  output logic                   port_y_data_oe_b
);

  // ****************************************************************
  // Input capture
  // ****************************************************************
  localparam int CW = ADDR_W + 4;
  localparam int SW = CW + DATA_W;

  logic [SW-1:0] x_pins;
  logic [SW-1:0] y_pins;
  logic [SW-1:0] x_smp;
  logic [SW-1:0] y_smp;

  assign x_pins = {port_x_address, x_select_low_n, x_select_high,
                   x_write_enable_n, x_to_y_pass_n, port_x_data_in};
  assign y_pins = {port_y_address, y_select_low_n, y_select_high,
                   y_write_enable_n, y_to_x_pass_n, port_y_data_in};

  // RQ3 edge capture
  // RQ12 input registered
  dps_in_reg #(.W(SW)) u_x_in (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .pin_in   (x_pins),
    .rst_val  ({SW{1'b1}}),
    .sync_out (x_smp)
  );

  dps_in_reg #(.W(SW)) u_y_in (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .pin_in   (y_pins),
    .rst_val  ({SW{1'b1}}),
    .sync_out (y_smp)
  );

  // Field split of the sampled groups
  logic [ADDR_W-1:0] x_addr;
  logic [ADDR_W-1:0] y_addr;
  logic [DATA_W-1:0] x_din;
  logic [DATA_W-1:0] y_din;
  logic              x_sel_n;
  logic              x_sel;
  logic              x_we_n;
  logic              x_pass_n;
  logic              y_sel_n;
  logic              y_sel;
  logic              y_we_n;
  logic              y_pass_n;

  assign {x_addr, x_sel_n, x_sel, x_we_n, x_pass_n, x_din} = x_smp;
  assign {y_addr, y_sel_n, y_sel, y_we_n, y_pass_n, y_din} = y_smp;

  // ****************************************************************
  // Operation decode
  // ****************************************************************

  // Decode used for both ports
  function automatic dps_op_e port_op(input logic sel_n, input logic sel,
                                      input logic we_n,
                                      input logic any_pass);
    // RQ13 deselect decode
    if (sel_n || !sel) begin
      port_op = DPS_OP_IDLE;
    // RQ10 write or read
    end else if (we_n == DPS_WE_WRITE) begin
      port_op = DPS_OP_WRITE;
    // RQ5 pass beats read
    end else if (any_pass) begin
      port_op = DPS_OP_IDLE;
    end else begin
      port_op = DPS_OP_READ;
    end
  endfunction

  logic    any_pass;
  logic    both_en;
  logic    pass_xy;
  logic    pass_yx;
  dps_op_e x_op;
  dps_op_e y_op;

  assign any_pass = (x_pass_n == DPS_PASS_ON) || (y_pass_n == DPS_PASS_ON);
  assign both_en  = !x_sel_n && x_sel && !y_sel_n && y_sel;
  // RQ4 pass directions
  // RQ14 both ports enabled
  assign pass_xy  = both_en && (x_pass_n == DPS_PASS_ON);
  assign pass_yx  = both_en && (y_pass_n == DPS_PASS_ON);
  // RQ2 independent ports
  assign x_op     = port_op(x_sel_n, x_sel, x_we_n, any_pass);
  assign y_op     = port_op(y_sel_n, y_sel, y_we_n, any_pass);

  // ****************************************************************
  // Memory array
  // ****************************************************************

  // RQ1 array storage
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] x_rd;
  logic [DATA_W-1:0] y_rd;
  logic              x_wr;
  logic              y_wr;

  assign x_wr = (x_op == DPS_OP_WRITE);
  assign y_wr = (y_op == DPS_OP_WRITE);

  // RQ7 read before write
  // RQ6 dual reads normal
  assign x_rd = mem[x_addr];
  assign y_rd = mem[y_addr];

  // RQ15 writes combine freely
  // RQ8 port Y wins
  // RQ20 no access when idle
  always_ff @(posedge mclk) begin
    if (clk_en) begin
      if (x_wr && !(y_wr && (y_addr == x_addr))) begin
        mem[x_addr] <= x_din;
      end
      if (y_wr) begin
        mem[y_addr] <= y_din;
      end
    end
  end

  // ****************************************************************
  // Output selection
  // ****************************************************************
  logic [DATA_W-1:0] x_word;
  logic [DATA_W-1:0] y_word;
  logic              x_load;
  logic              y_load;

  // RQ16 read with write
  // RQ19 two edge latency
  assign x_load = pass_yx || (x_op == DPS_OP_READ);
  assign y_load = pass_xy || (y_op == DPS_OP_READ);
  assign x_word = pass_yx ? y_din : x_rd;
  assign y_word = pass_xy ? x_din : y_rd;

  logic x_valid;
  logic y_valid;

  // RQ11 async output enable
  // RQ18 high-Z at power-up
  dps_out_drv #(.W(DATA_W)) u_x_out (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .load     (x_load),
    .drive    (x_load),
    .word     (x_word),
    .out_en_n (x_output_enable_n),
    .pin_out  (port_x_data_out),
    .pin_oe_b (port_x_data_oe_b),
    .valid    (x_valid)
  );

  dps_out_drv #(.W(DATA_W)) u_y_out (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .load     (y_load),
    .drive    (y_load),
    .word     (y_word),
    .out_en_n (y_output_enable_n),
    .pin_out  (port_y_data_out),
    .pin_oe_b (port_y_data_oe_b),
    .valid    (y_valid)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_deselect_hiz;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && (x_sel_n || !x_sel) && !pass_yx |=> !x_valid;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz) // RQ20
    else $error("deselected port X still drives");

  property p_pass_xy;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && pass_xy |=> y_valid && port_y_data_out == $past(x_din);
  endproperty
  a_pass_xy: assert property (p_pass_xy) // RQ4
    else $error("pass X to Y data wrong");

  property p_pass_yx;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && pass_yx |=> x_valid && port_x_data_out == $past(y_din);
  endproperty
  a_pass_yx: assert property (p_pass_yx) // RQ4
    else $error("pass Y to X data wrong");

  property p_pass_over_read;
    @(posedge mclk) disable iff (!rst_b)
    any_pass |-> x_op != DPS_OP_READ && y_op != DPS_OP_READ;
  endproperty
  a_pass_over_read: assert property (p_pass_over_read) // RQ5
    else $error("read while pass active");

  property p_old_data;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && y_wr && x_op == DPS_OP_READ && x_addr == y_addr
      && !pass_yx |=> port_x_data_out == $past(x_rd);
  endproperty
  a_old_data: assert property (p_old_data) // RQ7
    else $error("read did not return old word");

  property p_y_wins;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && x_wr && y_wr && x_addr == y_addr
      |=> mem[$past(y_addr)] == $past(y_din);
  endproperty
  a_y_wins: assert property (p_y_wins) // RQ8
    else $error("port Y write did not win");

  property p_oe_hiz;
    @(posedge mclk) disable iff (!rst_b)
    x_output_enable_n != DPS_OE_ON |-> port_x_data_oe_b;
  endproperty
  a_oe_hiz: assert property (p_oe_hiz) // RQ11
    else $error("port X driven with enable high");

  property p_read_latency;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && y_op == DPS_OP_READ && !pass_xy
      |=> y_valid && port_y_data_out == $past(y_rd);
  endproperty
  a_read_latency: assert property (p_read_latency) // RQ19
    else $error("port Y read data late or wrong");

  property p_deselect_hiz_y;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && (y_sel_n || !y_sel) && !pass_xy |=> !y_valid;
  endproperty
  a_deselect_hiz_y: assert property (p_deselect_hiz_y) // RQ20
    else $error("deselected port Y still drives");

  property p_oe_hiz_y;
    @(posedge mclk) disable iff (!rst_b)
    y_output_enable_n != DPS_OE_ON |-> port_y_data_oe_b;
  endproperty
  a_oe_hiz_y: assert property (p_oe_hiz_y) // RQ11
    else $error("port Y driven with enable high");

  property p_read_latency_x;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && x_op == DPS_OP_READ && !pass_yx
      |=> x_valid && port_x_data_out == $past(x_rd);
  endproperty
  a_read_latency_x: assert property (p_read_latency_x) // RQ19
    else $error("port X read data late or wrong");

  property p_old_data_y;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && x_wr && y_op == DPS_OP_READ && x_addr == y_addr
      |=> port_y_data_out == $past(mem[y_addr]);
  endproperty
  a_old_data_y: assert property (p_old_data_y) // RQ7
    else $error("port Y read did not return old word");

  property p_dual_read;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && x_op == DPS_OP_READ && y_op == DPS_OP_READ
      && x_addr == y_addr |=> port_x_data_out == port_y_data_out;
  endproperty
  a_dual_read: assert property (p_dual_read) // RQ6
    else $error("same-address reads differ");

  property p_reset_hiz;
    @(posedge mclk)
    !rst_b |-> port_x_data_oe_b && port_y_data_oe_b;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) // RQ18
    else $error("data port driven during reset");

  property p_x_write;
    @(posedge mclk) disable iff (!rst_b)
    clk_en && x_wr && !(y_wr && y_addr == x_addr)
      |=> mem[$past(x_addr)] == $past(x_din);
  endproperty
  a_x_write: assert property (p_x_write) // RQ10
    else $error("port X write did not land");

endmodule // dps_core

// file: test/dps_host_model.sv
// Purpose: Host at one data port, resolving the shared data wire
// Assumes: Requests change just after the rising edge
// Notes:   An undriven wire shows the inverse of its last level
`timescale 1ns/1ps

module dps_host_model
  import dps_pkg::*;
(
  // Clock
  input  wire logic                  mclk,
  // Host request
  input  wire logic                  drive_req,
  input  wire logic                  hold_off,
  input  wire logic [DPS_DATA_W-1:0] host_data,
  // Device side
  input  wire logic [DPS_DATA_W-1:0] dev_data,
  input  wire logic                  dev_oe_b,
  output logic                       out_en_n,
  output logic      [DPS_DATA_W-1:0] wire_data
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  logic [DPS_DATA_W-1:0] last_q;

  // enable off first
  // Raised with the drive itself, a full cycle ahead of the edge
  assign out_en_n  = drive_req | hold_off;
  // Floating wire must not repeat the old word, or a stale value passes
  assign wire_data = drive_req ? host_data : (!dev_oe_b ? dev_data : ~last_q);

  // Remember the wire level
  always_ff @(posedge mclk) begin
    last_q <= wire_data;
  end
endmodule // dps_host_model

// file: test/tb_dual_port_sync_sram_passthru.sv
// Purpose: Self-checking bench for the dual-port pass-through memory
// Assumes: Host models on both data ports; clock enable held high
// Notes:   Scoreboard predicts both outputs two edges after sampling
`timescale 1ns/1ps

module tb_dual_port_sync_sram_passthru
  import dps_pkg::*;
;
  // ****************************************************************
  // Stimulus, scoreboard and verdict
  // ****************************************************************
  typedef struct packed {
    logic                  sl_n;
    logic                  sh;
    logic                  we_n;
    logic                  pass_n;
    logic                  hold;
    logic [DPS_ADDR_W-1:0] a;
    logic [DPS_DATA_W-1:0] d;
  } dps_req_s;
  typedef struct packed {
    logic                  drv;
    logic [DPS_DATA_W-1:0] v;
  } dps_exp_s;

  logic                  mclk = 1'b0;
  logic                  rst_b = 1'b0;
  dps_req_s              xr, yr;
  dps_exp_s              xh, yh;
  dps_exp_s              xp_q [3];
  dps_exp_s              yp_q [3];
  logic [DPS_DATA_W-1:0] xin, yin, xout, yout;
  logic                  xoe_b, yoe_b, xoen, yoen;
  logic [DPS_DATA_W-1:0] mem [logic [DPS_ADDR_W-1:0]];
  int                    mismatches = 0;
  int                    checks = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  dps_core i_dut (
    .mclk(mclk), .rst_b(rst_b), .clk_en(1'b1),
    .port_x_address(xr.a), .x_select_low_n(xr.sl_n), .x_select_high(xr.sh),
    .x_write_enable_n(xr.we_n), .x_to_y_pass_n(xr.pass_n),
    .x_output_enable_n(xoen),
    .port_y_address(yr.a), .y_select_low_n(yr.sl_n), .y_select_high(yr.sh),
    .y_write_enable_n(yr.we_n), .y_to_x_pass_n(yr.pass_n),
    .y_output_enable_n(yoen),
    .port_x_data_in(xin), .port_x_data_out(xout), .port_x_data_oe_b(xoe_b),
    .port_y_data_in(yin), .port_y_data_out(yout), .port_y_data_oe_b(yoe_b));

  dps_host_model i_hx (.mclk(mclk), .drive_req(~xr.we_n | ~xr.pass_n),
    .hold_off(xr.hold), .host_data(xr.d), .dev_data(xout),
    .dev_oe_b(xoe_b), .out_en_n(xoen), .wire_data(xin));
  dps_host_model i_hy (.mclk(mclk), .drive_req(~yr.we_n | ~yr.pass_n),
    .hold_off(yr.hold), .host_data(yr.d), .dev_data(yout),
    .dev_oe_b(yoe_b), .out_en_n(yoen), .wire_data(yin));

  // Kinds: 0 deselect low-n + write, 1 read, 2 write, 3 pass + read,
  // 4 deselect high + write, 5 read with enable held off,
  // 6 write + pass, 7 idle
  function automatic dps_req_s rq(input int k, input int i,
                                  input logic [DPS_DATA_W-1:0] d);
    rq.sl_n   = (k == 0 || k == 7);
    rq.sh     = (k != 4);
    rq.we_n   = !(k inside {0, 2, 4, 6});
    rq.pass_n = !(k inside {3, 6});
    rq.hold   = (k == 5);
    rq.a      = (i == 8) ? '1 : DPS_ADDR_W'(i);
    rq.d      = d;
  endfunction

  function automatic logic [DPS_DATA_W-1:0] rnd();
    return {4'($urandom()), $urandom()};
  endfunction

  // Reads see the array before this cycle's writes; Y writes last
  function automatic void predict(input dps_req_s x, input dps_req_s y,
                                  output dps_exp_s ex, output dps_exp_s ey);
    logic xe, ye, rdok;
    xe   = !x.sl_n && x.sh;
    ye   = !y.sl_n && y.sh;
    rdok = x.pass_n && y.pass_n;
    ex   = '{1'b0, xh.v};
    ey   = '{1'b0, yh.v};
    if (xe && x.we_n && rdok) ex = '{1'b1, mem[x.a]};
    if (ye && y.we_n && rdok) ey = '{1'b1, mem[y.a]};
    if (xe && ye && !y.pass_n) ex = '{1'b1, y.d};
    if (xe && ye && !x.pass_n) ey = '{1'b1, x.d};
    if (xe && !x.we_n) mem[x.a] = x.d;
    if (ye && !y.we_n) mem[y.a] = y.d;
    xh = ex;
    yh = ey;
  endfunction

  // Two-edge pipeline of predictions, cleared with the design
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xh = '0;
      yh = '0;
      xp_q = '{default: '0};
      yp_q = '{default: '0};
    end else begin
      xp_q[2] = xp_q[1];
      yp_q[2] = yp_q[1];
      xp_q[1] = xp_q[0];
      yp_q[1] = yp_q[0];
      predict(xr, yr, xp_q[0], yp_q[0]);
    end
  end

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Outputs settle well before the falling edge
  always @(negedge mclk) begin
    if (rst_b) begin
      check(xout, xp_q[2].v);
      check(yout, yp_q[2].v);
      check(xoe_b, !(xp_q[2].drv && !xoen));
      check(yoe_b, !(yp_q[2].drv && !yoen));
    end
  end

  task automatic step(input dps_req_s x, input dps_req_s y);
    @(posedge mclk);
    xr <= x;
    yr <= y;
  endtask

  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Run needs about 350 cycles; 2000 leaves a wide margin
  initial begin
    #(2000 * 40);
    mismatches++;
    finish_test();
  end

  initial begin
    xr = rq(7, 0, '0);
    yr = rq(7, 0, '0);
    void'($urandom(32'hd0fa162e));
    repeat (2) @(negedge mclk);
    check({xoe_b, yoe_b, xout, yout}, {2'b11, 72'h0});
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    step(rq(7, 0, '0), rq(7, 0, '0));
    // fill both ends, collide in the middle
    for (int i = 0; i < 9; i++) step(rq(2, i, rnd()), rq(2, 8 - i, rnd()));
    // dual reads, same address in the middle
    for (int i = 0; i < 9; i++) step(rq(1, i, '0), rq(1, 8 - i, '0));
    $display("Test fill and read done");
    step(rq(2, 3, rnd()), rq(1, 3, '0));
    step(rq(1, 5, '0), rq(2, 5, rnd()));
    step(rq(1, 3, '0), rq(1, 5, '0));
    $display("Test collisions done");
    // passes in both directions override reads
    step(rq(3, 1, rnd()), rq(3, 2, rnd()));
    step(rq(6, 4, rnd()), rq(1, 4, '0));
    step(rq(1, 6, '0), rq(3, 6, rnd()));
    step(rq(1, 4, '0), rq(1, 6, '0));
    $display("Test pass-through done");
    // deselected writes ignored, pass needs both ports
    step(rq(0, 2, rnd()), rq(4, 7, rnd()));
    step(rq(4, 0, rnd()), rq(3, 1, rnd()));
    step(rq(1, 2, '0), rq(5, 7, '0));
    step(rq(7, 0, '0), rq(1, 0, '0));
    $display("Test deselect done");
    repeat (300)
      step(rq($urandom_range(7), $urandom_range(8), rnd()),
           rq($urandom_range(7), $urandom_range(8), rnd()));
    step(rq(7, 0, '0), rq(7, 0, '0));
    repeat (4) @(posedge mclk);
    $display("Test random done");
    finish_test();
  end
endmodule // tb_dual_port_sync_sram_passthru
